// file: design/rct_timer.sv
`timescale 1ns/1ps
`include "rct_map.svh"

// Notes on behaviour
// [RULE1] high flag set on high byte rollover
// [RULE2] high flag requests interrupt when enabled
// [RULE3] flags clear only by software zero write
// [RULE4] low flag set on every low rollover
// [RULE5] low interrupt needs low enable bit
// [RULE6] falling capture pin edge copies count, interrupts
// [RULE7] split bit picks 16-bit or two 8-bit
// [RULE8] run gates all, or high byte in split
// [RULE9] clock: system/12 or external/8 resynchronised
// [RULE10] split: per-byte select system or external; code picks the undivided system clock or the base tick
// [RULE11] reload bytes hold reload or captured value
// [RULE12] overflow reloads from matching reload bytes; code wraps to zero in capture mode
// [RULE13] software writes reserved bit as zero
module rct_timer (
  input  wire logic                  clock_i,
  input  wire logic                  arst_n_i,
  input  wire rct_pkg::rct_sfr_req_s sfr_req_i,
  input  wire logic                  timer_irq_enable_i,
  input  wire logic                  high_byte_clock_select_i,
  input  wire logic                  low_byte_clock_select_i,
  input  wire logic                  ext_clk_i,
  input  wire logic                  capture_input_pin_i,
  output logic [7:0]                 sfr_rdata_o,
  output logic                       irq_o
);

  rct_pkg::rct_ctrl_s ctrl_ff;
  rct_pkg::rct_ctrl_s wr_ctrl;
  logic [7:0]         count_low_byte_ff;
  logic [7:0]         count_high_byte_ff;
  logic [7:0]         reload_low_byte_ff;
  logic [7:0]         reload_high_byte_ff;
  logic [7:0]         nxt_count_low_byte;
  logic [7:0]         nxt_count_high_byte;
  logic [7:0]         reload_low_src;
  logic [7:0]         reload_high_src;
  logic               pin_q_ff;
  logic               sys_tick;
  logic               ext_tick;
  logic               base_tick;
  logic               tick_low;
  logic               tick_high;
  logic               inc_low;
  logic               inc_high;
  logic               low_roll;
  logic               high_roll;
  logic               capture;
  logic               wr_ctrl_hit;

  // ========================================================
  // helpers
  function automatic logic byte_tick(input logic use_sys, input logic base);
    byte_tick = use_sys | base;
  endfunction

  function automatic logic wr_hit(input rct_pkg::rct_sfr_req_s req, input logic [7:0] ofs);
    wr_hit = req.wr && (req.addr == ofs);
  endfunction

  // ========================================================
  // count clock
  rct_prescale u_prescale (
    .clock_i    (clock_i),
    .arst_n_i   (arst_n_i),
    .ext_clk_i  (ext_clk_i),
    .sys_tick_o (sys_tick),
    .ext_tick_o (ext_tick)
  );

  // [RULE9] base clock choice
  assign base_tick = ctrl_ff.external_clock_select ? ext_tick : sys_tick;

  // [RULE10] per-byte clock choice
  assign tick_low  = ctrl_ff.split_mode_select ?
                     byte_tick(low_byte_clock_select_i, base_tick) : base_tick;
  assign tick_high = ctrl_ff.split_mode_select ?
                     byte_tick(high_byte_clock_select_i, base_tick) : base_tick;

  // ========================================================
  // counting structure
  // [RULE7] [RULE8] split and run gating
  assign inc_low  = ctrl_ff.split_mode_select ? tick_low :
                    (ctrl_ff.run_control & tick_low);
  assign inc_high = ctrl_ff.split_mode_select ? (ctrl_ff.run_control & tick_high) :
                    (inc_low && (count_low_byte_ff == `RCT_BYTE_MAX));

  assign low_roll  = inc_low && (count_low_byte_ff == `RCT_BYTE_MAX);
  assign high_roll = inc_high && (count_high_byte_ff == `RCT_BYTE_MAX);

  // in capture mode the reload bytes hold a capture, so the count wraps to zero instead
  assign reload_low_src  = ctrl_ff.capture_enable ? `RCT_CAPTURE_BASE : reload_low_byte_ff;
  assign reload_high_src = ctrl_ff.capture_enable ? `RCT_CAPTURE_BASE : reload_high_byte_ff;

  // [RULE12] reload selection per mode
  always_comb begin
    nxt_count_low_byte = count_low_byte_ff;
    if (wr_hit(sfr_req_i, `RCT_OFS_COUNT_LOW)) begin
      nxt_count_low_byte = sfr_req_i.wdata;
    end else if (low_roll) begin
      if (ctrl_ff.split_mode_select || high_roll) begin
        nxt_count_low_byte = reload_low_src;
      end else begin
        nxt_count_low_byte = `RCT_RST_BYTE;
      end
    end else if (inc_low) begin
      nxt_count_low_byte = count_low_byte_ff + 8'h01;
    end
  end

  always_comb begin
    nxt_count_high_byte = count_high_byte_ff;
    if (wr_hit(sfr_req_i, `RCT_OFS_COUNT_HIGH)) begin
      nxt_count_high_byte = sfr_req_i.wdata;
    end else if (high_roll) begin
      nxt_count_high_byte = reload_high_src;
    end else if (inc_high) begin
      nxt_count_high_byte = count_high_byte_ff + 8'h01;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_low_byte_ff  <= `RCT_RST_BYTE;
      count_high_byte_ff <= `RCT_RST_BYTE;
    end else begin
      count_low_byte_ff  <= nxt_count_low_byte;
      count_high_byte_ff <= nxt_count_high_byte;
    end
  end

  // ========================================================
  // capture on the pin's falling edge
  // [RULE6] falling edge detect
  assign capture = ctrl_ff.capture_enable & pin_q_ff & ~capture_input_pin_i;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_q_ff <= 1'b1;
    end else begin
      pin_q_ff <= capture_input_pin_i;
    end
  end

  // a capture beats a software write to the same reload byte
  // [RULE11] reload or captured value
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reload_low_byte_ff  <= `RCT_RST_BYTE;
      reload_high_byte_ff <= `RCT_RST_BYTE;
    end else if (capture) begin
      reload_low_byte_ff  <= count_low_byte_ff;
      reload_high_byte_ff <= count_high_byte_ff;
    end else begin
      if (wr_hit(sfr_req_i, `RCT_OFS_RELOAD_LOW)) begin
        reload_low_byte_ff <= sfr_req_i.wdata;
      end
      if (wr_hit(sfr_req_i, `RCT_OFS_RELOAD_HIGH)) begin
        reload_high_byte_ff <= sfr_req_i.wdata;
      end
    end
  end

  // ========================================================
  // control register
  assign wr_ctrl_hit = wr_hit(sfr_req_i, `RCT_OFS_CONTROL);
  assign wr_ctrl     = rct_pkg::rct_ctrl_s'(sfr_req_i.wdata);

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_ff <= rct_pkg::rct_ctrl_s'(`RCT_RST_CONTROL);
    end else begin
      // one process owns every field, so the byte keeps a single driver
      if (wr_ctrl_hit) begin
        ctrl_ff.low_byte_irq_enable   <= wr_ctrl.low_byte_irq_enable;
        ctrl_ff.capture_enable        <= wr_ctrl.capture_enable;
        ctrl_ff.split_mode_select     <= wr_ctrl.split_mode_select;
        ctrl_ff.run_control           <= wr_ctrl.run_control;
        ctrl_ff.external_clock_select <= wr_ctrl.external_clock_select;
      end
      // flags: hardware set wins over a software clear in the same cycle
      // [RULE1] [RULE3] high flag
      if (high_roll) begin
        ctrl_ff.high_byte_overflow_flag <= 1'b1;
      end else if (wr_ctrl_hit) begin
        ctrl_ff.high_byte_overflow_flag <= wr_ctrl.high_byte_overflow_flag;
      end
      // [RULE4] [RULE3] low flag
      if (low_roll) begin
        ctrl_ff.low_byte_overflow_flag <= 1'b1;
      end else if (wr_ctrl_hit) begin
        ctrl_ff.low_byte_overflow_flag <= wr_ctrl.low_byte_overflow_flag;
      end
      // [RULE13] reserved bit held at zero
      ctrl_ff.reserved <= 1'b0;
    end
  end

  // ========================================================
  // interrupt request
  // [RULE2] [RULE5] [RULE6] request sources
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= timer_irq_enable_i &
               (ctrl_ff.high_byte_overflow_flag |
                (ctrl_ff.low_byte_irq_enable & ctrl_ff.low_byte_overflow_flag) |
                capture);
    end
  end

  // ========================================================
  // register read, unmapped addresses read zero
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_req_i.rd) begin
      if (sfr_req_i.addr == `RCT_OFS_CONTROL) begin
        sfr_rdata_o <= ctrl_ff;
      end else if (sfr_req_i.addr == `RCT_OFS_RELOAD_LOW) begin
        sfr_rdata_o <= reload_low_byte_ff;
      end else if (sfr_req_i.addr == `RCT_OFS_RELOAD_HIGH) begin
        sfr_rdata_o <= reload_high_byte_ff;
      end else if (sfr_req_i.addr == `RCT_OFS_COUNT_LOW) begin
        sfr_rdata_o <= count_low_byte_ff;
      end else if (sfr_req_i.addr == `RCT_OFS_COUNT_HIGH) begin
        sfr_rdata_o <= count_high_byte_ff;
      end else begin
        sfr_rdata_o <= 8'h00;
      end
    end
  end

endmodule

// file: design/rct_map.svh
`ifndef RCT_MAP_SVH
`define RCT_MAP_SVH

// ==========================================================
// register offsets on the special function register bus
`define RCT_OFS_CONTROL     8'hc8
`define RCT_OFS_RELOAD_LOW  8'hca
`define RCT_OFS_RELOAD_HIGH 8'hcb
`define RCT_OFS_COUNT_LOW   8'hcc
`define RCT_OFS_COUNT_HIGH  8'hcd

// ==========================================================
// control register field positions
`define RCT_BIT_HIGH_FLAG   7
`define RCT_BIT_LOW_FLAG    6
`define RCT_BIT_LOW_IRQ_EN  5
`define RCT_BIT_CAPTURE_EN  4
`define RCT_BIT_SPLIT       3
`define RCT_BIT_RUN         2
`define RCT_BIT_RESERVED    1
`define RCT_BIT_EXT_CLK     0

// ==========================================================
// reset values, byte maximum and capture-mode wrap value
`define RCT_RST_CONTROL     8'h00
`define RCT_RST_BYTE        8'h00
`define RCT_BYTE_MAX        8'hff
`define RCT_CAPTURE_BASE    8'h00

// ==========================================================
// count clock dividers
`define RCT_SYS_DIV         4'hc
`define RCT_EXT_DIV         3'h7

`endif

// file: design/rct_pkg.sv
package rct_pkg;

  // ========================================================
  // control register layout, bit 7 first
  typedef struct packed {
    logic high_byte_overflow_flag;
    logic low_byte_overflow_flag;
    logic low_byte_irq_enable;
    logic capture_enable;
    logic split_mode_select;
    logic run_control;
    logic reserved;
    logic external_clock_select;
  } rct_ctrl_s;

  // ========================================================
  // one register bus request, sampled on the clock
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rct_sfr_req_s;

endpackage

// file: design/rct_prescale.sv
`timescale 1ns/1ps
`include "rct_map.svh"

module rct_prescale (
  input  wire logic clock_i,
  input  wire logic arst_n_i,
  input  wire logic ext_clk_i,
  output logic      sys_tick_o,
  output logic      ext_tick_o
);

  logic [3:0] sys_cnt_ff;
  logic [2:0] ext_cnt_ff;
  logic       ext_q_ff;
  logic       ext_rise;

  // ========================================================
  // system clock divided by 12
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sys_cnt_ff <= 4'h0;
      sys_tick_o <= 1'b0;
    end else if (sys_cnt_ff == `RCT_SYS_DIV - 4'h1) begin
      sys_cnt_ff <= 4'h0;
      sys_tick_o <= 1'b1;
    end else begin
      sys_cnt_ff <= sys_cnt_ff + 4'h1;
      sys_tick_o <= 1'b0;
    end
  end

  // ========================================================
  // external clock divided by 8, counted on its rising edges
  // the external clock must stay below half the system clock
  assign ext_rise = ext_clk_i & ~ext_q_ff;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ext_q_ff   <= 1'b0;
      ext_cnt_ff <= 3'h0;
      ext_tick_o <= 1'b0;
    end else begin
      ext_q_ff   <= ext_clk_i;
      ext_tick_o <= ext_rise && (ext_cnt_ff == `RCT_EXT_DIV);
      if (ext_rise) begin
        ext_cnt_ff <= ext_cnt_ff + 3'h1;
      end
    end
  end

endmodule

// file: verif/rct_timer_props.sv
`timescale 1ns/1ps
// ==========
// bus and interrupt relations seen at the top ports
module rct_timer_props (
  input wire logic                  clock_i,
  input wire logic                  arst_n_i,
  input wire rct_pkg::rct_sfr_req_s sfr_req_i,
  input wire logic                  timer_irq_enable_i,
  input wire logic                  high_byte_clock_select_i,
  input wire logic                  low_byte_clock_select_i,
  input wire logic                  ext_clk_i,
  input wire logic                  capture_input_pin_i,
  input wire logic [7:0]            sfr_rdata_o,
  input wire logic                  irq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  logic [7:0] last_ctrl_ff;
  logic       ctrl_wr;
  logic       mapped;
  assign ctrl_wr = sfr_req_i.wr && sfr_req_i.addr == 8'hc8;
  assign mapped  = sfr_req_i.addr inside {8'hc8, [8'hca:8'hcd]};
  // own copy of the control byte, so reads can be judged without internals
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      last_ctrl_ff <= 8'h00;
    end else if (ctrl_wr) begin
      last_ctrl_ff <= sfr_req_i.wdata;
    end
  end
  // a steady pin means no capture can overwrite the reload bytes
  sequence s_quiet;
    !sfr_req_i.wr && $stable(capture_input_pin_i);
  endsequence
  sequence s_ctrl_rd;
    sfr_req_i.rd && sfr_req_i.addr == 8'hc8;
  endsequence
  property p_irq_gate;
    !timer_irq_enable_i |=> !irq_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");
  property p_rdata_hold;
    !sfr_req_i.rd |=> $stable(sfr_rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_unmapped;
    sfr_req_i.rd && !mapped |=> sfr_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_reserved;
    s_ctrl_rd |=> !sfr_rdata_o[1];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");
  property p_ctrl_fields;
    s_ctrl_rd |=> sfr_rdata_o[5:0] == {$past(last_ctrl_ff[5:2]), 1'b0, $past(last_ctrl_ff[0])};
  endproperty
  a_ctrl_fields: assert property (p_ctrl_fields) else $error("control readback");
  property p_flag_write;
    ctrl_wr ##1 s_quiet ##1 s_ctrl_rd |=>
      (sfr_rdata_o[7:6] & $past(sfr_req_i.wdata[7:6], 3)) == $past(sfr_req_i.wdata[7:6], 3);
  endproperty
  a_flag_write: assert property (p_flag_write) else $error("flag lost");
  property p_reload_back;
    (sfr_req_i.wr && sfr_req_i.addr inside {8'hca, 8'hcb} && $stable(capture_input_pin_i))
      ##1 s_quiet ##1 (sfr_req_i.rd && sfr_req_i.addr == $past(sfr_req_i.addr, 2))
      |=> sfr_rdata_o == $past(sfr_req_i.wdata, 3);
  endproperty
  a_reload_back: assert property (p_reload_back) else $error("reload readback");
  property p_sticky_irq;
    irq_o && $past(irq_o) && timer_irq_enable_i && !ctrl_wr && !$past(ctrl_wr)
      && !$past(ctrl_wr, 2) |=> irq_o;
  endproperty
  a_sticky_irq: assert property (p_sticky_irq) else $error("irq dropped");
endmodule

bind rct_timer rct_timer_props props_u (
  .clock_i(clock_i), .arst_n_i(arst_n_i), .sfr_req_i(sfr_req_i),
  .timer_irq_enable_i(timer_irq_enable_i), .high_byte_clock_select_i(high_byte_clock_select_i),
  .low_byte_clock_select_i(low_byte_clock_select_i), .ext_clk_i(ext_clk_i),
  .capture_input_pin_i(capture_input_pin_i), .sfr_rdata_o(sfr_rdata_o), .irq_o(irq_o));

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic                  clock_i, arst_n_i, irq_en, hb_sel, lb_sel, ext_clk, pin, irq, seen;
  logic [7:0]            rdata, v, a, b;
  rct_pkg::rct_sfr_req_s req;
  int                    err_total, checks, seed, i;

  rct_timer dut_u (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .sfr_req_i(req), .timer_irq_enable_i(irq_en),
    .high_byte_clock_select_i(hb_sel), .low_byte_clock_select_i(lb_sel), .ext_clk_i(ext_clk),
    .capture_input_pin_i(pin), .sfr_rdata_o(rdata), .irq_o(irq));

  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  function automatic logic [7:0] ticks(input int span, input int div);
    return 8'(span / div);
  endfunction
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] ad, input logic [7:0] d);
    @(negedge clock_i);
    req = '{ad, d, 1'b1, 1'b0};
    @(negedge clock_i);
    req.wr = 1'b0;
  endtask
  task rd(input logic [7:0] ad, output logic [7:0] d);
    @(negedge clock_i);
    req = '{ad, 8'h00, 1'b0, 1'b1};
    @(negedge clock_i);
    req.rd = 1'b0;
    d = rdata;
  endtask
  task rchk(input logic [7:0] ad, input logic [7:0] exp);
    logic [7:0] d;
    rd(ad, d);
    chk(d, exp);
  endtask
  task wait_flag(input logic [7:0] m);
    logic [7:0] d;
    d = 8'h00;
    for (int k = 0; k < 400 && (d & m) != m; k++) rd(8'hc8, d);
    chk(d & m, m);
  endtask
  // count advance of one count byte over exactly n clock edges
  task diff(input logic [7:0] ad, input int n, output logic [7:0] dd);
    rd(ad, a);
    repeat (n - 2) @(negedge clock_i);
    rd(ad, b);
    dd = b - a;
  endtask
  task test_done;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #1000000;
    err_total++;
    test_done;
  end

  initial begin
    seed = 84;
    err_total = 0;
    checks = 0;
    req = '0;
    {irq_en, hb_sel, lb_sel, ext_clk, seen} = 5'h00;
    pin = 1'b1;
    arst_n_i = 1'b0;
    repeat (5) @(posedge clock_i);
    @(negedge clock_i);
    arst_n_i = 1'b1;
    // ==========
    // reset values, 0xc9 is unmapped
    for (i = 0; i < 6; i++) rchk(8'hc8 + 8'(i), 8'h00);
    // reserved bit always written as zero by software
    for (i = 0; i < 8; i++) begin
      v = 8'($random(seed)) & 8'h39;
      wr(8'hc8, v);
      rchk(8'hc8, v);
      a = 8'($random(seed));
      wr(8'hca + 8'(i % 2), a);
      rchk(8'hca + 8'(i % 2), a);
    end
    // ==========
    // 16-bit wrap
    wr(8'hc8, 8'h00);
    irq_en = 1'b1;
    a = 8'($random(seed));
    b = 8'($random(seed));
    wr(8'hca, a);
    wr(8'hcb, b);
    wr(8'hcc, 8'hff);
    wr(8'hcd, 8'hff);
    wr(8'hc8, 8'h04);
    wait_flag(8'hc0);
    wr(8'hc8, 8'hc0);
    rchk(8'hcc, a);
    rchk(8'hcd, b);
    repeat (50) @(negedge clock_i);
    chk({7'h00, irq}, 8'h01);
    rchk(8'hc8, 8'hc0);
    wr(8'hc8, 8'h00);
    repeat (3) @(negedge clock_i);
    chk({7'h00, irq}, 8'h00);
    // ==========
    // split: low byte free-runs, high byte stopped
    a = 8'($random(seed));
    wr(8'hca, a);
    wr(8'hcc, 8'hff);
    wr(8'hcd, 8'hff);
    wr(8'hc8, 8'h08);
    wait_flag(8'h40);
    rchk(8'hcc, a);
    rchk(8'hc8, 8'h48);
    chk({7'h00, irq}, 8'h00);
    rchk(8'hcd, 8'hff);
    wr(8'hc8, 8'h68);
    rchk(8'hc8, 8'h68);
    chk({7'h00, irq}, 8'h01);
    // zero reload bytes make a rollover look like plain modulo counting
    wr(8'hca, 8'h00);
    wr(8'hcb, 8'h00);
    lb_sel = 1'b1;
    diff(8'hcc, 40, v);
    chk(v, ticks(40, 1));
    lb_sel = 1'b0;
    wr(8'hc8, 8'h0c);
    hb_sel = 1'b1;
    diff(8'hcd, 40, v);
    chk(v, ticks(40, 1));
    hb_sel = 1'b0;
    // ==========
    // count clocks
    wr(8'hc8, 8'h04);
    diff(8'hcc, 120, v);
    chk(v, ticks(120, 12));
    wr(8'hc8, 8'h01);
    wr(8'hcc, 8'h00);
    wr(8'hc8, 8'h05);
    for (i = 0; i < 16; i++) begin
      @(negedge clock_i);
      ext_clk = 1'b1;
      repeat (2) @(negedge clock_i);
      ext_clk = 1'b0;
    end
    repeat (4) @(negedge clock_i);
    rchk(8'hcc, ticks(16, 8));
    // ==========
    // capture mode: a wrap clears the count, reload bytes are kept
    wr(8'hca, 8'h5a);
    wr(8'hcb, 8'ha5);
    wr(8'hcc, 8'hff);
    wr(8'hcd, 8'hff);
    wr(8'hc8, 8'h14);
    wait_flag(8'hc0);
    rchk(8'hcc, 8'h00);
    rchk(8'hcd, 8'h00);
    rchk(8'hca, 8'h5a);
    // ==========
    // capture of a frozen count
    wr(8'hc8, 8'h00);
    v = 8'($random(seed));
    wr(8'hcc, v);
    wr(8'hcd, ~v);
    wr(8'hc8, 8'h10);
    @(negedge clock_i);
    pin = 1'b0;
    repeat (4) begin
      @(negedge clock_i);
      seen = seen | irq;
    end
    chk({7'h00, seen}, 8'h01);
    chk({7'h00, irq}, 8'h00);
    pin = 1'b1;
    rchk(8'hca, v);
    rchk(8'hcb, ~v);
    test_done;
  end
endmodule
